// *** design/wdc_prescale.sv ***
// Watchdog clock prescaler: divider counting only while enabled, giving a one-cycle tick enable.
// Assumes enable and clear come from logic on the same clock.
module wdc_prescale
    import wdc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       clr,
    input  wire logic       en,
    input  wire logic [2:0] sel,
    output logic            tick
);

    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] mask;

    assign mask = wdc_div_mask(sel);
    assign tick = en && ((div_q & mask) == mask);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            div_q <= BYTE_RST;
        else if (clr)
            div_q <= BYTE_RST;
        else if (en)
            div_q <= div_q + 8'h01;
    end

endmodule : wdc_prescale

// *** design/wdc_top.sv ***
// Watchdog timer control with Wishbone register access and one interrupt.
// Assumes RST is the power-on reset; SYS_RST is any other chip reset, asynchronous.
//
// Operation
// - Clearing the run bit stops the counter and setting it starts counting.
// - Run and low-power bits act only when the option field is all ones (timer mode).
// - Writing 1 to the clear bit zeroes the count; writing 0 does nothing.
// - The clear bit reads 1 while a clear is pending and 0 once it is done.
// - Counter overflow sets the timeout flag, which stays set until software or a chip reset (SYS_RST) clears it.
// - In timer mode the low-power bit chooses halt or keep counting in Idle/Power-down.
// - A watchdog reset sets the reset flag in hardware; software should clear it.
// - The reset flag clears on power-on, sets on watchdog reset, holds on other resets.
// - The prescale field selects division 1/1 to 1/256, largest by default.
// - With a nonzero clock divider in Power-down the watchdog reset does not fire.
// - Control writes are taken only while the timed-access unlock is open.
// - Power-on sets all prescale bits; other resets leave them unchanged.
module wdc_top
    import wdc_pkg::*;
#(
    parameter int CNT_W = 6
)
(
    input  wire logic              REF_CLK,
    input  wire logic              RST,
    input  wire logic              CYC_I,
    input  wire logic              STB_I,
    input  wire logic              WE_I,
    input  wire logic [ADR_W-1:0]  ADR_I,
    input  wire logic [3:0]        SEL_I,
    input  wire logic [31:0]       DAT_I,
    output logic      [31:0]       DAT_O,
    output logic                   ACK_O,
    output logic                   IRQ_O,
    input  wire logic [3:0]        CFG_OPT,
    input  wire logic              SYS_RST,
    input  wire logic              IDLE,
    input  wire logic              PDOWN,
    input  wire logic [7:0]        CLK_DIV,
    output logic                   WDT_RST_O
);

    logic              ack_q;
    logic [31:0]       dat_q;
    logic [31:0]       rd_d;
    logic [3:0]        cfg_s1_q;
    logic [3:0]        cfg_s2_q;
    logic              srst_s1_q;
    logic              srst_s2_q;
    logic              acc;
    logic              wr;
    logic              ctrl_wr;
    logic              ctrl_ok;
    logic              gp_mode;
    logic              low_pwr;
    logic              cnt_en;
    logic              tick;
    logic              ovf;
    logic              rst_block;
    logic              soft_rst;
    logic              clr_done;
    logic              run_q;
    logic              lp_q;
    logic              tf_q;
    logic              rf_q;
    logic [2:0]        ps_q;
    logic              clr_q;
    logic [1:0]        clr_cnt_q;
    logic [CNT_W-1:0]  cnt_q;
    logic              wdt_rst_q;
    wdc_ta_e           ta_q;
    logic [3:0]        ta_cnt_q;
    wdc_evt_s          stat_q;
    wdc_evt_s          mask_q;
    wdc_evt_s          evt;
    wdc_ctrl_s         wd;
    wdc_ctrl_s         rd_ctrl;

    // Option straps and the chip reset come from outside this clock
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            cfg_s1_q  <= 4'h0;
            cfg_s2_q  <= 4'h0;
            srst_s1_q <= 1'b1;
            srst_s2_q <= 1'b1;
        end
        else
        begin
            cfg_s1_q  <= CFG_OPT;
            cfg_s2_q  <= cfg_s1_q;
            srst_s1_q <= SYS_RST;
            srst_s2_q <= srst_s1_q;
        end
    end

    // Bus slave: answer one cycle after the request, unmapped reads give zero
    assign acc     = CYC_I && STB_I && !ack_q;
    assign wr      = acc && WE_I && SEL_I[0];
    assign ctrl_wr = wr && wdc_hit(ADR_I, CTRL_IDX);
    assign ctrl_ok = ctrl_wr && (ta_q == TA_OPEN);
    assign wd      = wdc_ctrl_s'(DAT_I[7:0]);
    assign ACK_O   = ack_q;
    assign DAT_O   = dat_q;

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            ack_q <= 1'b0;
        else
            ack_q <= acc;
    end

    assign rd_ctrl = '{run: run_q, clr: clr_q, tf: tf_q, lp: lp_q, rf: rf_q, ps: ps_q};

    always_comb
    begin
        rd_d = 32'h0000_0000;
        if (wdc_hit(ADR_I, CTRL_IDX))
            rd_d[7:0] = rd_ctrl;
        else if (wdc_hit(ADR_I, STAT_IDX))
            rd_d[2:0] = stat_q;
        else if (wdc_hit(ADR_I, MASK_IDX))
            rd_d[2:0] = mask_q;
        else if (wdc_hit(ADR_I, UNLK_IDX))
            rd_d[0] = (ta_q == TA_OPEN);
        else if (wdc_hit(ADR_I, CNT_IDX))
            rd_d[CNT_W-1:0] = cnt_q;
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            dat_q <= 32'h0000_0000;
        else if (acc && !WE_I)
            dat_q <= rd_d;
    end

    // Timed access: two key writes open a short window for one control write
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            ta_q     <= TA_LOCK;
            ta_cnt_q <= 4'h0;
        end
        else if (soft_rst || ctrl_wr)
            ta_q <= TA_LOCK;
        else
        begin
            case (ta_q)
                TA_LOCK:
                    if (wr && wdc_hit(ADR_I, UNLK_IDX) && DAT_I[7:0] == KEY_FIRST)
                        ta_q <= TA_KEY;
                TA_KEY:
                    if (wr && wdc_hit(ADR_I, UNLK_IDX))
                    begin
                        ta_q     <= (DAT_I[7:0] == KEY_SECOND) ? TA_OPEN : TA_LOCK;
                        ta_cnt_q <= 4'(TA_WIN_CYC - 1);
                    end
                TA_OPEN:
                    if (ta_cnt_q == 4'h0)
                        ta_q <= TA_LOCK;
                    else
                        ta_cnt_q <= ta_cnt_q - 4'h1;
                default:
                    ta_q <= TA_LOCK;
            endcase
        end
    end

    // Mode and gating
    assign gp_mode   = (cfg_s2_q == OPT_GP);
    assign low_pwr   = IDLE || PDOWN;
    assign cnt_en    = gp_mode ? (run_q && !(low_pwr && !lp_q)) : 1'b1;
    assign rst_block = PDOWN && (CLK_DIV != 8'h00);
    assign soft_rst  = srst_s2_q || wdt_rst_q;

    // Run and low-power bits; a watchdog or chip reset clears both
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            run_q <= 1'b0;
            lp_q  <= 1'b0;
        end
        else if (soft_rst)
        begin
            run_q <= 1'b0;
            lp_q  <= 1'b0;
        end
        else if (ctrl_ok)
        begin
            run_q <= wd.run;
            lp_q  <= wd.lp;
        end
    end

    // Counter clear stays pending for a fixed latency, then completes
    assign clr_done = clr_q && (clr_cnt_q == 2'(CLR_LAT_CYC - 1));

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            clr_q     <= 1'b0;
            clr_cnt_q <= 2'h0;
        end
        else if (soft_rst)
            clr_q <= 1'b0;
        else if (ctrl_ok && wd.clr)
        begin
            clr_q     <= 1'b1;
            clr_cnt_q <= 2'h0;
        end
        else if (clr_done)
            clr_q <= 1'b0;
        else if (clr_q)
            clr_cnt_q <= clr_cnt_q + 2'h1;
    end

    wdc_prescale wdc_prescale_inst (
        .clk  (REF_CLK),
        .rst  (RST),
        .clr  (soft_rst || clr_done),
        .en   (cnt_en),
        .sel  (ps_q),
        .tick (tick)
    );

    assign ovf = tick && (&cnt_q) && !clr_done && !soft_rst;

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            cnt_q <= '0;
        else if (soft_rst || clr_done)
            cnt_q <= '0;
        else if (tick)
            cnt_q <= cnt_q + 1'b1;
    end

    // Timeout flag: hardware set wins over a software clear
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            tf_q <= 1'b0;
        else if (ovf)
            tf_q <= 1'b1;
        else if (srst_s2_q)
            tf_q <= 1'b0;
        else if (ctrl_ok)
            tf_q <= wd.tf;
    end

    // Device reset pulse on overflow in reset-timer mode
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            wdt_rst_q <= 1'b0;
        else
            wdt_rst_q <= ovf && !gp_mode && !rst_block;
    end

    assign WDT_RST_O = wdt_rst_q;

    // Reset flag and prescale survive every reset but power-on
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            rf_q <= 1'b0;
        else if (wdt_rst_q)
            rf_q <= 1'b1;
        else if (ctrl_ok)
            rf_q <= wd.rf;
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            ps_q <= PS_RST;
        else if (ctrl_ok)
            ps_q <= wd.ps;
    end

    // Interrupt: sticky events, cleared by reading status; a new event wins
    assign evt = '{ta_bad: ctrl_wr && !ctrl_ok, wdt_rst: wdt_rst_q, ovf: ovf};

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            stat_q <= EVT_RST;
        else if (acc && !WE_I && wdc_hit(ADR_I, STAT_IDX))
            stat_q <= evt;
        else
            stat_q <= stat_q | evt;
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            mask_q <= EVT_RST;
        else if (wr && wdc_hit(ADR_I, MASK_IDX))
            mask_q <= wdc_evt_s'(DAT_I[2:0]);
    end

    assign IRQ_O = |(stat_q & mask_q);

    // Checks
    chk_run_stop: assert property (@(posedge REF_CLK) disable iff (RST)
        (gp_mode && !run_q && !clr_done && !soft_rst) |=> $stable(cnt_q))
        else $error("counter moved while stopped");

    chk_mode_gate: assert property (@(posedge REF_CLK) disable iff (RST)
        (!gp_mode && !soft_rst && !clr_done && ps_q == 3'h0) |=> !$stable(cnt_q))
        else $error("reset-timer mode did not count");

    chk_clear_zero: assert property (@(posedge REF_CLK) disable iff (RST)
        (ctrl_ok && wd.clr && !soft_rst) ##1 !soft_rst |-> clr_q ##2 (cnt_q == '0))
        else $error("clear did not zero counter");

    chk_clear_read: assert property (@(posedge REF_CLK) disable iff (RST)
        (ctrl_ok && wd.clr && !soft_rst) ##1 (!soft_rst && !ctrl_ok) [*2] |=> !clr_q)
        else $error("clear pending too long");

    chk_tf_set: assert property (@(posedge REF_CLK) disable iff (RST)
        ovf |=> tf_q)
        else $error("overflow did not set flag");

    chk_tf_hold: assert property (@(posedge REF_CLK) disable iff (RST)
        (tf_q && !ctrl_ok && !srst_s2_q) |=> tf_q)
        else $error("timeout flag lost");

    chk_lp_halt: assert property (@(posedge REF_CLK) disable iff (RST)
        (gp_mode && low_pwr && !lp_q) |-> !tick)
        else $error("tick in low power with halt selected");

    chk_rf_set: assert property (@(posedge REF_CLK) disable iff (RST)
        wdt_rst_q |=> rf_q)
        else $error("watchdog reset did not set flag");

    chk_rf_keep: assert property (@(posedge REF_CLK) disable iff (RST)
        (srst_s2_q && !wdt_rst_q && !ctrl_ok) |=> (rf_q == $past(rf_q)))
        else $error("reset flag changed on other reset");

    chk_pd_block: assert property (@(posedge REF_CLK) disable iff (RST)
        (ovf && rst_block) |=> !WDT_RST_O)
        else $error("reset fired while blocked");

    chk_ta_guard: assert property (@(posedge REF_CLK) disable iff (RST)
        (ctrl_wr && ta_q != TA_OPEN && !soft_rst) |=> $stable(ps_q) && $stable(run_q))
        else $error("locked control write took effect");

    chk_ps_keep: assert property (@(posedge REF_CLK) disable iff (RST)
        (srst_s2_q && !ctrl_ok) |=> $stable(ps_q))
        else $error("prescale changed on other reset");

    chk_rst_out: assert property (@(posedge REF_CLK) disable iff (RST)
        (ovf && !gp_mode && !rst_block) |=> WDT_RST_O ##1 !WDT_RST_O)
        else $error("overflow reset pulse wrong");

endmodule : wdc_top

// *** dv/tb.sv ***
// Self-checking testbench for the watchdog control block, driven over classic Wishbone.
// Assumes the design packs control, status, mask, unlock and counter registers as its package says.
module tb
    import wdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic              clk = 1'b0;
    logic              rst, cyc, stb, we, sys_rst, idle, pdown;
    logic              ack, irq, wdt_rst;
    logic [ADR_W-1:0]  adr;
    logic [3:0]        sel, cfg_opt;
    logic [31:0]       dat_w, dat_r;
    logic [7:0]        clk_div, rd, c1;
    int                n_errors, n_checks, r, n, p, i;

    always #25 clk = ~clk;

    wdc_top #(.CNT_W(6)) wdc_top_inst (
        .REF_CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .IRQ_O(irq),
        .CFG_OPT(cfg_opt), .SYS_RST(sys_rst), .IDLE(idle), .PDOWN(pdown),
        .CLK_DIV(clk_div), .WDT_RST_O(wdt_rst)
    );

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask : tick

    // Entered just after a rising edge; returns just after the idle edge
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int k;
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= {2'h0, idx, 2'h0};
        dat_w <= {24'h0, wd};
        for (k = 0; k < 16; k++)
        begin
            @(posedge clk);
            if (ack === 1'b1)
                break;
        end
        if (k == 16)
        begin
            n_errors++;
            finish_test();
        end
        else
        begin
            rd = dat_r[7:0];
            cyc <= 1'b0;
            stb <= 1'b0;
            we  <= 1'b0;
            @(posedge clk);
        end
    endtask : bus

    task automatic rd_is(input logic [7:0] idx, input logic [7:0] exp, input string what);
        bus(1'b0, idx, 8'h00);
        check(what, rd, exp);
    endtask : rd_is

    // Both keys and the control write fit well inside the unlock window
    task automatic ctl(input logic [7:0] v);
        bus(1'b1, UNLK_IDX, KEY_FIRST);
        bus(1'b1, UNLK_IDX, KEY_SECOND);
        bus(1'b1, CTRL_IDX, v);
    endtask : ctl

    // Two reads three cycles apart; difference in counts modulo the counter width
    task automatic cnt_delta();
        bus(1'b0, CNT_IDX, 8'h00);
        c1 = rd;
        bus(1'b0, CNT_IDX, 8'h00);
    endtask : cnt_delta

    initial
    begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = '0;
        sel = 4'hF;
        dat_w = '0;
        cfg_opt = OPT_GP;
        sys_rst = 1'b0;
        idle = 1'b0;
        pdown = 1'b0;
        clk_div = 8'h00;
        n_errors = 0;
        n_checks = 0;
        tick(12);
        rst <= 1'b0;
        tick(1);
        rd_is(CTRL_IDX, 8'h07, "control after power-on");
        rd_is(STAT_IDX, 8'h00, "status after power-on");
        rd_is(8'h10, 8'h00, "unmapped read");
        bus(1'b1, MASK_IDX, 8'h04);
        bus(1'b1, CTRL_IDX, 8'h80);
        tick(1);
        check("irq on locked write", irq, 1'b1);
        rd_is(CTRL_IDX, 8'h07, "control after locked write");
        rd_is(STAT_IDX, 8'h04, "status locked write");
        tick(1);
        check("irq after status read", irq, 1'b0);
        ctl(8'h80);
        cnt_delta();
        check("counter runs", (rd - c1) & 8'h3F, 8'h03);
        ctl(8'h00);
        cnt_delta();
        check("counter stopped", rd, c1);
        idle <= 1'b1;
        ctl(8'h80);
        cnt_delta();
        check("counter halted in idle", rd, c1);
        ctl(8'h90);
        cnt_delta();
        check("counter runs in idle", (rd - c1) & 8'h3F, 8'h03);
        idle <= 1'b0;
        for (n = 0; n < 40; n++)
        begin
            bus(1'b0, CTRL_IDX, 8'h00);
            if (rd[5] === 1'b1)
                break;
        end
        check("timeout flag set", rd[5], 1'b1);
        ctl(8'h20);
        tick(70);
        rd_is(CTRL_IDX, 8'h20, "timeout flag held");
        check("overflow masked", irq, 1'b0);
        bus(1'b1, MASK_IDX, 8'h01);
        tick(1);
        check("overflow unmasked", irq, 1'b1);
        rd_is(STAT_IDX, 8'h01, "status overflow");
        tick(1);
        check("irq cleared", irq, 1'b0);
        ctl(8'h00);
        rd_is(CTRL_IDX, 8'h00, "timeout flag cleared");
        // Clear restarts the divider too, so the count after a fixed wait is known
        for (p = 0; p < 8; p++)
        begin
            r = (p == 0) ? 1 : (2 << p);
            ctl(8'hC0 | 8'(p));
            tick(20 * r);
            bus(1'b0, CNT_IDX, 8'h00);
            check("prescale count", (rd >= 8'd19) && (rd <= 8'd22), 1'b1);
        end
        rd_is(CTRL_IDX, 8'h87, "clear done");
        ctl(8'h87);
        bus(1'b0, CNT_IDX, 8'h00);
        check("clear written 0", rd >= 8'd19, 1'b1);
        ctl(8'h00);
        bus(1'b0, STAT_IDX, 8'h00);
        cfg_opt <= 4'h0;
        for (n = 0; n < 300; n++)
        begin
            @(posedge clk);
            if (wdt_rst === 1'b1)
                break;
        end
        check("watchdog reset pulse", n < 300, 1'b1);
        tick(2);
        rd_is(CTRL_IDX, 8'h28, "control after watchdog reset");
        rd_is(STAT_IDX, 8'h03, "status after watchdog reset");
        pdown <= 1'b1;
        clk_div <= 8'h01;
        bus(1'b0, STAT_IDX, 8'h00);
        n = 0;
        for (i = 0; i < 150; i++)
        begin
            @(posedge clk);
            if (wdt_rst === 1'b1)
                n++;
        end
        check("reset pulses in power-down", n, 0);
        rd_is(STAT_IDX, 8'h01, "overflow in power-down");
        sys_rst <= 1'b1;
        tick(1);
        sys_rst <= 1'b0;
        tick(4);
        rd_is(CTRL_IDX, 8'h08, "control after system reset");
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(1);
        rd_is(CTRL_IDX, 8'h07, "control after second power-on");
        finish_test();
    end

endmodule : tb

// *** pkg/wdc_pkg.sv ***
// Package for the watchdog control block: register map, field layout,
// reset values, cycle counts, shared types and decode helpers.
// Assumes a 32-bit classic Wishbone bus with byte addresses; one register per word.
package wdc_pkg;

    localparam int          ADR_W       = 12;
    localparam int          DIV_W       = 8;
    // Register indices; byte address is four times the index
    localparam logic [7:0]  CTRL_IDX    = 8'hAA;
    localparam logic [7:0]  STAT_IDX    = 8'hB0;
    localparam logic [7:0]  MASK_IDX    = 8'hB1;
    localparam logic [7:0]  UNLK_IDX    = 8'hB2;
    localparam logic [7:0]  CNT_IDX     = 8'hB3;
    // Unlock keys, arbitrary values
    localparam logic [7:0]  KEY_FIRST   = 8'h5A;
    localparam logic [7:0]  KEY_SECOND  = 8'hA5;
    // Option field value that selects general purpose timer mode
    localparam logic [3:0]  OPT_GP      = 4'hF;
    // Reset values
    localparam logic [2:0]  PS_RST      = 3'h7;
    localparam logic [2:0]  EVT_RST     = 3'h0;
    localparam logic [7:0]  BYTE_RST    = 8'h00;
    // Cycle counts
    localparam int          CLR_LAT_CYC = 2;
    localparam int          TA_WIN_CYC  = 8;

    typedef struct packed {
        logic       run;
        logic       clr;
        logic       tf;
        logic       lp;
        logic       rf;
        logic [2:0] ps;
    } wdc_ctrl_s;

    // Sticky event bits in status and mask registers
    typedef struct packed {
        logic ta_bad;
        logic wdt_rst;
        logic ovf;
    } wdc_evt_s;

    typedef enum logic [1:0] {
        TA_LOCK = 2'b00,
        TA_KEY  = 2'b01,
        TA_OPEN = 2'b10
    } wdc_ta_e;

    // Low bits of the divider that must all be set for a tick
    function automatic logic [DIV_W-1:0] wdc_div_mask(input logic [2:0] sel);
        case (sel)
            3'h0:    wdc_div_mask = 8'h00;
            3'h1:    wdc_div_mask = 8'h03;
            3'h2:    wdc_div_mask = 8'h07;
            3'h3:    wdc_div_mask = 8'h0F;
            3'h4:    wdc_div_mask = 8'h1F;
            3'h5:    wdc_div_mask = 8'h3F;
            3'h6:    wdc_div_mask = 8'h7F;
            default: wdc_div_mask = 8'hFF;
        endcase
    endfunction : wdc_div_mask

    function automatic logic wdc_hit(input logic [ADR_W-1:0] adr, input logic [7:0] idx);
        wdc_hit = (adr[ADR_W-1:2] == {2'h0, idx});
    endfunction : wdc_hit

endpackage : wdc_pkg
